// ==== shared/ecd_pkg.sv ====
/*
  constants, register map and types of the expander configuration and
  direction block.
  assumes: included before every other file of the block.
*/
package ecd_pkg;

  // register offsets reached through the serial pointer
  localparam logic [7:0] ECD_OFF_IN_LO   = 8'h00;
  localparam logic [7:0] ECD_OFF_IN_HI   = 8'h01;
  localparam logic [7:0] ECD_OFF_PH0_LO  = 8'h02;
  localparam logic [7:0] ECD_OFF_PH0_HI  = 8'h03;
  localparam logic [7:0] ECD_OFF_DIR_LO  = 8'h06;
  localparam logic [7:0] ECD_OFF_DIR_HI  = 8'h07;
  localparam logic [7:0] ECD_OFF_PH1_LO  = 8'h0A;
  localparam logic [7:0] ECD_OFF_PH1_HI  = 8'h0B;
  localparam logic [7:0] ECD_OFF_MASTER  = 8'h0E;
  localparam logic [7:0] ECD_OFF_CONFIG  = 8'h0F;
  localparam logic [7:0] ECD_OFF_PORTINT = 8'h10;
  localparam logic [7:0] ECD_OFF_PORTEND = 8'h17;

  // configuration register bit positions
  localparam int ECD_BIT_BLINK_EN  = 0;
  localparam int ECD_BIT_FLIP      = 1;
  localparam int ECD_BIT_GLOBAL    = 2;
  localparam int ECD_BIT_INT_EN    = 3;
  localparam int ECD_BIT_LVL_FIRST = 4;
  localparam int ECD_BIT_LVL_SEC   = 5;
  localparam int ECD_BIT_STATUS    = 7;

  // reset values
  localparam logic [5:0] ECD_RST_CONFIG = 6'h0C;
  localparam logic [7:0] ECD_RST_DIR    = 8'hFF;
  localparam logic [7:0] ECD_RST_PHASE  = 8'hFF;
  localparam logic [7:0] ECD_RST_INT    = 8'h00;

  // serial bit count at which a byte is complete
  localparam logic [3:0] ECD_BYTE_BITS = 4'h8;

  // serial slave states
  typedef enum logic [3:0] {
    ECD_IDLE, ECD_ADDR, ECD_ACK_ADDR, ECD_CMD, ECD_ACK_CMD,
    ECD_WDATA, ECD_ACK_W, ECD_RDATA, ECD_ACK_R
  } ecd_state_t;

endpackage : ecd_pkg

// ==== shared/ecd_ctl_if.sv ====
/*
  control bundle from the register file to the port bank and the
  interrupt/extra output pin logic.
  assumes: all users run on the same mclk.
*/
`timescale 1ns/1ns
interface ecd_ctl_if;
  logic [15:0] portDirectionBits;
  logic [15:0] phase0;
  logic [15:0] phase1;
  logic        blinkEn;
  logic        blinkFlip;
  logic        globalInt;
  logic        intEnable;
  logic        pinLevelFirstPhase;
  logic        pinLevelSecondPhase;
  logic [3:0]  masterNib;
  logic [63:0] perNib;
  logic        inputRead;
  logic        changeSeen;

  modport regs (
    output portDirectionBits, phase0, phase1, blinkEn, blinkFlip,
    output globalInt, intEnable, pinLevelFirstPhase, pinLevelSecondPhase,
    output masterNib, perNib, inputRead,
    input  changeSeen
  );
  modport bank (
    input  portDirectionBits, phase0, phase1, blinkEn, blinkFlip,
    input  globalInt, masterNib, perNib, inputRead,
    output changeSeen
  );
  modport irq (
    input  blinkEn, blinkFlip, intEnable, masterNib,
    input  pinLevelFirstPhase, pinLevelSecondPhase, changeSeen
  );
endinterface : ecd_ctl_if

// ==== rtl/ecd_port_bank.sv ====
/*
  the sixteen open-drain ports: direction, level select, intensity
  select and input change detection.
  assumes: port inputs synchronous to mclk; register file drives ctl.
*/
`timescale 1ns/1ns
module ecd_port_bank (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // control bundle
  ecd_ctl_if.bank          ctl,
  // port pins
  input  wire logic [15:0] portPinsIn,
  output logic      [15:0] portPinsOe,
  output logic      [63:0] portIntensity
);
  import ecd_pkg::*;

  logic [15:0] pinsPrev_r;
  logic        change_r;
  logic [15:0] level;
  logic [63:0] intensity_nxt;
  logic        edgeSeen;
  logic        armed_r;

  assign level = (ctl.blinkEn && ctl.blinkFlip) ? ctl.phase1 : ctl.phase0;

  // transitions only count on ports set as inputs, and only once the
  // history holds a real sample: pins idle high behind pull-ups, so the
  // zero reset value would otherwise fake a change right after reset
  assign edgeSeen = armed_r &
                    (|((portPinsIn ^ pinsPrev_r) & ctl.portDirectionBits));

  // history valid from the second cycle after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  // previous input sample
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinsPrev_r <= 16'h0000;
    end else begin
      pinsPrev_r <= portPinsIn;
    end
  end

  // sticky until inputs read; a new edge wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      change_r <= 1'b0;
    end else begin
      change_r <= edgeSeen | (change_r & ~ctl.inputRead);
    end
  end
  assign ctl.changeSeen = change_r;

  // drive low only for outputs with a zero level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      portPinsOe <= 16'h0000;
    end else begin
      portPinsOe <= ~ctl.portDirectionBits & ~level;
    end
  end

  always_comb begin
    intensity_nxt = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 16; i++) begin
      if (!ctl.portDirectionBits[i]) begin
        intensity_nxt[4*i +: 4] = ctl.globalInt ? ctl.masterNib
                                                : ctl.perNib[4*i +: 4];
      end
    end
  end

  // registered intensity for the pwm stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      portIntensity <= 64'h0000_0000_0000_0000;
    end else begin
      portIntensity <= intensity_nxt;
    end
  end

endmodule : ecd_port_bank

// ==== rtl/ecd_irq_pin.sv ====
/*
  the combined interrupt / seventeenth output pin.
  assumes: ctl comes from the register file and port bank on mclk.
*/
`timescale 1ns/1ns
module ecd_irq_pin (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // control bundle
  ecd_ctl_if.irq          ctl,
  // pin and intensity
  output logic            irqPinOe,
  output logic      [3:0] extraIntensity
);
  import ecd_pkg::*;

  logic level;

  // phase level; blink off keeps phase 0
  assign level = (ctl.blinkEn && ctl.blinkFlip) ? ctl.pinLevelSecondPhase
                                                : ctl.pinLevelFirstPhase;

  // interrupt mode follows change, else level bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqPinOe <= 1'b0;
    end else if (ctl.intEnable) begin
      irqPinOe <= ctl.changeSeen;
    end else begin
      irqPinOe <= ~level;
    end
  end

  // low nibble of master register either way
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      extraIntensity <= 4'h0;
    end else begin
      extraIntensity <= ctl.masterNib;
    end
  end

endmodule : ecd_irq_pin

// ==== rtl/ecd_expander_config_and_direction.sv ====
/*
  top of the expander configuration block: two-wire serial slave,
  register file, port bank and combined interrupt/extra output pin.
  assumes: scl and sda inputs already synchronous to mclk, and the
  bus is slow against mclk so every scl edge spans several cycles.
*/
//
// Contract
// - Global bit clear: output ports use their own nibbles, pin 17 uses 0x0E low.
// - Global bit set: every output, pin 17 too, uses 0x0E bits 3..0.
// - Interrupts off: the combined pin follows only the two level bits.
// - Interrupts on: the combined pin reports input changes instead.
// - Interrupts and blink off: pin low for level bit 0, released for 1.
// - Blink on in phase 0: pin low or released by the first level bit.
// - Blink on in phase 1: pin follows the second level bit only.
// - Status bit 7 reads 1 after an input change, 0 otherwise.
// - Bit 6 of the configuration reads 0 and ignores writes.
// - A direction bit of 1 makes an input, 0 makes an output.
// - Direction registers read back as last written.
// - Blink flip picks phase 1 levels only while blink is enabled.
// - An output level of 1 releases the port, 0 pulls it low.
`timescale 1ns/1ns
module ecd_expander_config_and_direction #(
  parameter logic [6:0] SLAVE_ADDR = 7'h20
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // two-wire serial bus
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // port pins
  input  wire logic [15:0] portPinsIn,
  output logic      [15:0] portPinsOut,
  output logic      [15:0] portPinsOe,
  // combined interrupt / extra output pin
  input  wire logic        irqOrExtraOutputPinIn,
  output logic             irqOrExtraOutputPinOut,
  output logic             irqOrExtraOutputPinOe,
  // intensity selection for the pwm stage
  output logic      [63:0] portIntensity,
  output logic      [3:0]  extraIntensity
);
  import ecd_pkg::*;

  ecd_ctl_if ctl ();

  // serial line history
  logic       sclD_r;
  logic       sdaD_r;
  // serial slave state
  ecd_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic [7:0] txByte_r;
  logic       rnw_r;
  logic       mAck_r;
  logic       sdaOe_r;
  // register file
  logic [5:0] config_r;
  logic [7:0] dirLo_r;
  logic [7:0] dirHi_r;
  logic [7:0] ph0Lo_r;
  logic [7:0] ph0Hi_r;
  logic [7:0] ph1Lo_r;
  logic [7:0] ph1Hi_r;
  logic [7:0] master_r;
  logic [7:0] portInt_r [8];
  // decode
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       byteDone;
  logic       addrMatch;
  logic       wrEn;
  logic       loadTx;
  logic [7:0] readData;
  logic [2:0] bitIdx;
  logic [2:0] intIdx;

  // open-drain pins never drive high
  assign sdaOut                 = 1'b0;
  assign portPinsOut            = 16'h0000;
  assign irqOrExtraOutputPinOut = 1'b0;
  assign sdaOe                  = sdaOe_r;

  // one-cycle line history for edge and start/stop detection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclIn;
      sdaD_r <= sdaIn;
    end
  end

  // bus events
  assign sclRise   = sclIn & ~sclD_r;
  assign sclFall   = ~sclIn & sclD_r;
  assign startSeen = sclIn & sclD_r & sdaD_r & ~sdaIn;
  assign stopSeen  = sclIn & sclD_r & ~sdaD_r & sdaIn;
  assign byteDone  = sclFall & (bitCnt_r == ECD_BYTE_BITS);
  assign addrMatch = (shift_r[7:1] == SLAVE_ADDR);
  assign wrEn      = byteDone & (state_r == ECD_WDATA);
  assign loadTx    = sclFall & (((state_r == ECD_ACK_ADDR) & rnw_r) |
                                ((state_r == ECD_ACK_R) & mAck_r));
  assign bitIdx    = ~bitCnt_r[2:0];   // 7 - bits already sent
  assign intIdx    = ptr_r[2:0];

  // slave sequence; a start restarts from any state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ECD_IDLE;
    end else if (startSeen) begin
      state_r <= ECD_ADDR;
    end else if (stopSeen) begin
      state_r <= ECD_IDLE;
    end else if (sclFall) begin
      case (state_r)
        ECD_ADDR: begin
          if (byteDone) begin
            state_r <= addrMatch ? ECD_ACK_ADDR : ECD_IDLE;
          end
        end
        ECD_ACK_ADDR: state_r <= rnw_r ? ECD_RDATA : ECD_CMD;
        ECD_CMD: begin
          if (byteDone) begin
            state_r <= ECD_ACK_CMD;
          end
        end
        ECD_ACK_CMD:  state_r <= ECD_WDATA;
        ECD_WDATA: begin
          if (byteDone) begin
            state_r <= ECD_ACK_W;
          end
        end
        ECD_ACK_W:    state_r <= ECD_WDATA;
        ECD_RDATA: begin
          if (byteDone) begin
            state_r <= ECD_ACK_R;
          end
        end
        ECD_ACK_R:    state_r <= mAck_r ? ECD_RDATA : ECD_IDLE;
        default:      state_r <= ECD_IDLE;
      endcase
    end
  end

  // bit counter counts rising scl edges inside a byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_r <= 4'h0;
    end else if (startSeen || stopSeen || byteDone) begin
      bitCnt_r <= 4'h0;
    end else if (sclRise && (state_r == ECD_ADDR || state_r == ECD_CMD ||
                 state_r == ECD_WDATA || state_r == ECD_RDATA)) begin
      bitCnt_r <= bitCnt_r + 4'h1;
    end
  end

  // receive shift and master acknowledge sample
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= 8'h00;
      rnw_r   <= 1'b0;
      mAck_r  <= 1'b0;
    end else begin
      if (sclRise) begin
        shift_r <= {shift_r[6:0], sdaIn};
      end
      if (byteDone && state_r == ECD_ADDR) begin
        rnw_r <= shift_r[0];
      end
      if (sclRise && state_r == ECD_ACK_R) begin
        mAck_r <= ~sdaIn;
      end
    end
  end

  // register pointer: set by the command byte, steps after each data byte written or loaded for a read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r <= 8'h00;
    end else if (byteDone && state_r == ECD_CMD) begin
      ptr_r <= shift_r;
    end else if (wrEn || loadTx) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // transmit byte captured as each read byte starts, so data is stable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txByte_r <= 8'h00;
    end else if (loadTx) begin
      txByte_r <= readData;
    end
  end

  // sda drive: acks and read bits change only on falling scl
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe_r <= 1'b0;
    end else if (startSeen || stopSeen) begin
      sdaOe_r <= 1'b0;
    end else if (sclFall) begin
      case (state_r)
        ECD_ADDR:     sdaOe_r <= byteDone & addrMatch;
        ECD_CMD:      sdaOe_r <= byteDone;
        ECD_WDATA:    sdaOe_r <= byteDone;
        ECD_ACK_ADDR: sdaOe_r <= rnw_r & ~readData[7];
        ECD_RDATA:    sdaOe_r <= ~byteDone & ~txByte_r[bitIdx];
        ECD_ACK_R:    sdaOe_r <= mAck_r & ~readData[7];
        default:      sdaOe_r <= 1'b0;
      endcase
    end
  end

  // configuration register; bit 6 and bit 7 are not stored
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_r <= ECD_RST_CONFIG;
    end else if (wrEn && ptr_r == ECD_OFF_CONFIG) begin
      config_r <= shift_r[5:0];
    end
  end

  // direction registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dirLo_r <= ECD_RST_DIR;
      dirHi_r <= ECD_RST_DIR;
    end else if (wrEn) begin
      if (ptr_r == ECD_OFF_DIR_LO) begin
        dirLo_r <= shift_r;
      end else if (ptr_r == ECD_OFF_DIR_HI) begin
        dirHi_r <= shift_r;
      end
    end
  end

  // blink phase level registers; reset releases every port
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph0Lo_r <= ECD_RST_PHASE;
      ph0Hi_r <= ECD_RST_PHASE;
      ph1Lo_r <= ECD_RST_PHASE;
      ph1Hi_r <= ECD_RST_PHASE;
    end else if (wrEn) begin
      if (ptr_r == ECD_OFF_PH0_LO) begin
        ph0Lo_r <= shift_r;
      end else if (ptr_r == ECD_OFF_PH0_HI) begin
        ph0Hi_r <= shift_r;
      end else if (ptr_r == ECD_OFF_PH1_LO) begin
        ph1Lo_r <= shift_r;
      end else if (ptr_r == ECD_OFF_PH1_HI) begin
        ph1Hi_r <= shift_r;
      end
    end
  end

  // intensity registers: master/extra and two nibbles per byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      master_r <= ECD_RST_INT;
      for (int i = 0; i < 8; i++) begin
        portInt_r[i] <= ECD_RST_INT;
      end
    end else if (wrEn) begin
      if (ptr_r == ECD_OFF_MASTER) begin
        master_r <= shift_r;
      end else if (ptr_r >= ECD_OFF_PORTINT && ptr_r <= ECD_OFF_PORTEND) begin
        portInt_r[intIdx] <= shift_r;
      end
    end
  end

  // read-back mux; unmapped offsets read zero
  always_comb begin
    readData = 8'h00;
    if (ptr_r == ECD_OFF_IN_LO) begin
      readData = portPinsIn[7:0];
    end else if (ptr_r == ECD_OFF_IN_HI) begin
      readData = portPinsIn[15:8];
    end else if (ptr_r == ECD_OFF_PH0_LO) begin
      readData = ph0Lo_r;
    end else if (ptr_r == ECD_OFF_PH0_HI) begin
      readData = ph0Hi_r;
    end else if (ptr_r == ECD_OFF_DIR_LO) begin
      readData = dirLo_r;
    end else if (ptr_r == ECD_OFF_DIR_HI) begin
      readData = dirHi_r;
    end else if (ptr_r == ECD_OFF_PH1_LO) begin
      readData = ph1Lo_r;
    end else if (ptr_r == ECD_OFF_PH1_HI) begin
      readData = ph1Hi_r;
    end else if (ptr_r == ECD_OFF_MASTER) begin
      readData = master_r;
    end else if (ptr_r == ECD_OFF_CONFIG) begin
      readData = {ctl.changeSeen, 1'b0, config_r};
    end else if (ptr_r >= ECD_OFF_PORTINT && ptr_r <= ECD_OFF_PORTEND) begin
      readData = portInt_r[intIdx];
    end
  end

  // control bundle to the port bank and the combined pin
  assign ctl.portDirectionBits   = {dirHi_r, dirLo_r};
  assign ctl.phase0              = {ph0Hi_r, ph0Lo_r};
  assign ctl.phase1              = {ph1Hi_r, ph1Lo_r};
  assign ctl.blinkEn             = config_r[ECD_BIT_BLINK_EN];
  assign ctl.blinkFlip           = config_r[ECD_BIT_FLIP];
  assign ctl.globalInt           = config_r[ECD_BIT_GLOBAL];
  assign ctl.intEnable           = config_r[ECD_BIT_INT_EN];
  assign ctl.pinLevelFirstPhase  = config_r[ECD_BIT_LVL_FIRST];
  assign ctl.pinLevelSecondPhase = config_r[ECD_BIT_LVL_SEC];
  assign ctl.masterNib           = master_r[3:0];
  assign ctl.perNib = {portInt_r[7], portInt_r[6], portInt_r[5],
                       portInt_r[4], portInt_r[3], portInt_r[2],
                       portInt_r[1], portInt_r[0]};
  // reading an input register clears the change status
  assign ctl.inputRead = loadTx & (ptr_r == ECD_OFF_IN_LO ||
                                   ptr_r == ECD_OFF_IN_HI);

  // sixteen ports
  ecd_port_bank uBank (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .ctl           (ctl.bank),
    .portPinsIn    (portPinsIn),
    .portPinsOe    (portPinsOe),
    .portIntensity (portIntensity)
  );

  // combined interrupt / extra output
  ecd_irq_pin uIrq (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .ctl            (ctl.irq),
    .irqPinOe       (irqOrExtraOutputPinOe),
    .extraIntensity (extraIntensity)
  );

endmodule : ecd_expander_config_and_direction

// ==== testbench/ecd_monitor.sv ====
/*
  checker of the expander configuration block, watching top ports only.
  assumes: bound to the top module; scl phases last several mclk cycles.
*/
`timescale 1ns/1ns
module ecd_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // serial bus
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  // port pins
  input wire logic [15:0] portPinsIn,
  input wire logic [15:0] portPinsOut,
  input wire logic [15:0] portPinsOe,
  // combined pin and intensities
  input wire logic        irqOrExtraOutputPinIn,
  input wire logic        irqOrExtraOutputPinOut,
  input wire logic        irqOrExtraOutputPinOe,
  input wire logic [63:0] portIntensity,
  input wire logic [3:0]  extraIntensity
);
  logic        sclPrev_r;
  logic [3:0]  sinceFall_r;
  logic [15:0] pinsPrev_r;
  logic [3:0]  sinceToggle_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // cycles since an scl fall; saturating keeps long idle quiet
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_r   <= 1'b1;
      sinceFall_r <= 4'hF;
    end else begin
      sclPrev_r   <= sclIn;
      sinceFall_r <= (sclPrev_r && !sclIn) ? 4'h0 :
                     sinceFall_r + {3'h0, sinceFall_r != 4'hF};
    end
  end

  // cycles since any port level moved
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinsPrev_r    <= 16'h0000;
      sinceToggle_r <= 4'hF;
    end else begin
      pinsPrev_r    <= portPinsIn;
      sinceToggle_r <= (pinsPrev_r != portPinsIn) ? 4'h0 :
                       sinceToggle_r + {3'h0, sinceToggle_r != 4'hF};
    end
  end

  openDrain_a: assert property (
    !sdaOut && portPinsOut == 16'h0000 && !irqOrExtraOutputPinOut)
    else $error("an open-drain output drove high");
  resetQuiet_a: assert property ($rose(rst_b) |->
    (portPinsOe == 16'h0000 && !irqOrExtraOutputPinOe) [*2])
    else $error("pins active right after reset");
  portOeCause_a: assert property (
    !$stable(portPinsOe) |-> sinceFall_r <= 4'h5)
    else $error("port drive moved without a register write");
  intensCause_a: assert property (
    !$stable({portIntensity, extraIntensity}) |-> sinceFall_r <= 4'h5)
    else $error("intensity moved without a register write");
  irqOeCause_a: assert property (!$stable(irqOrExtraOutputPinOe) |->
    sinceFall_r <= 4'h5 || sinceToggle_r <= 4'h5)
    else $error("combined pin moved without a cause");
  irqClear_a: assert property (
    $fell(irqOrExtraOutputPinOe) |-> sinceFall_r <= 4'h5)
    else $error("combined pin released without a bus access");
  ackTiming_a: assert property (
    $rose(sdaOe) |-> !sclIn && sinceFall_r <= 4'h3)
    else $error("sda pulled away from an scl fall");
  ackHold_a: assert property (
    sclIn && sclPrev_r |-> $stable(sdaOe))
    else $error("sda drive moved while scl high");

  cover property ($rose(irqOrExtraOutputPinOe));
  cover property (!$stable(portPinsOe));
  cover property (!$stable(portIntensity));
endmodule : ecd_monitor

bind ecd_expander_config_and_direction ecd_monitor mon (
  .mclk(mclk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .portPinsIn(portPinsIn),
  .portPinsOut(portPinsOut), .portPinsOe(portPinsOe),
  .irqOrExtraOutputPinIn(irqOrExtraOutputPinIn),
  .irqOrExtraOutputPinOut(irqOrExtraOutputPinOut),
  .irqOrExtraOutputPinOe(irqOrExtraOutputPinOe),
  .portIntensity(portIntensity), .extraIntensity(extraIntensity)
);

// ==== testbench/ecd_host_model.sv ====
/*
  two-wire bus master model that reaches the registers.
  assumes: sda wired with a pull-up; 4 mclk cycles per scl phase.
*/
`timescale 1ns/1ns
module ecd_host_model #(
  parameter logic [6:0] ADDR = 7'h20
) (
  // clock
  input  wire logic mclk,
  // serial bus
  input  wire logic sdaLine,
  output logic      scl = 1'b1,
  output logic      sda = 1'b1
);
  int nacks = 0;

  // one bus phase; lines move just after an edge only
  task automatic drive(input logic c, input logic d);
    scl <= c;
    sda <= d;
    repeat (4) @(posedge mclk);
  endtask : drive

  // also serves as repeated start, scl is lowered first
  task automatic start;
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
  endtask : start

  task automatic stop;
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask : stop

  task automatic byteOut(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b0, b[i]);
      drive(1'b1, b[i]);
    end
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    if (sdaLine !== 1'b0) nacks++;
  endtask : byteOut

  task automatic byteIn(output logic [7:0] b, input logic nack);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      b[i] = sdaLine;
    end
    drive(1'b0, nack);
    drive(1'b1, nack);
  endtask : byteIn

  task automatic writeReg(input logic [7:0] p, input logic [7:0] d);
    start;
    byteOut({ADDR, 1'b0});
    byteOut(p);
    byteOut(d);
    stop;
  endtask : writeReg

  // single byte read, pointer kept across the repeated start
  task automatic readReg(input logic [7:0] p, output logic [7:0] d);
    start;
    byteOut({ADDR, 1'b0});
    byteOut(p);
    start;
    byteOut({ADDR, 1'b1});
    byteIn(d, 1'b1);
    stop;
  endtask : readReg
endmodule : ecd_host_model

// ==== testbench/ecd_expander_config_and_direction_tb.sv ====
/*
  self-checking bench of the expander configuration block.
  assumes: host model on the serial bus; ports pulled up outside.
*/
`timescale 1ns/1ns
module ecd_expander_config_and_direction_tb;
  import ecd_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl;
  logic        sdaDrv;
  logic        sdaOe;
  logic        irqOe;
  logic [15:0] pins = 16'hFFFF;
  logic [15:0] pinsOe;
  logic [63:0] inten;
  logic [3:0]  extraInt;
  logic [7:0]  rd;
  int          errorCnt = 0;
  int          compares = 0;

  // wire levels: pull-ups lose to any open-drain pull
  wire logic sdaIn = sdaDrv & ~sdaOe;
  wire logic [15:0] pinLvl = pins & ~pinsOe;

  initial forever #5 mclk = ~mclk;

  ecd_host_model host (.mclk(mclk), .sdaLine(sdaIn), .scl(scl), .sda(sdaDrv));

  ecd_expander_config_and_direction dut (
    .mclk(mclk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaIn),
    .sdaOut(), .sdaOe(sdaOe), .portPinsIn(pinLvl), .portPinsOut(),
    .portPinsOe(pinsOe), .irqOrExtraOutputPinIn(~irqOe),
    .irqOrExtraOutputPinOut(), .irqOrExtraOutputPinOe(irqOe),
    .portIntensity(inten), .extraIntensity(extraInt)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrapUp;
    $display("compares=%0d mismatches=%0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrapUp

  // write, then let the pin effects settle
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.writeReg(p, d);
    repeat (3) @(posedge mclk);
  endtask : wr

  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    host.readReg(p, rd);
    check(rd, exp);
  endtask : rdc

  task automatic resetValues;
    rdc(ECD_OFF_CONFIG, {2'b00, ECD_RST_CONFIG});
    rdc(ECD_OFF_DIR_LO, ECD_RST_DIR);
    check(pinsOe, 16'h0000);
  endtask : resetValues

  // mixed directions over both bytes, levels from phase 0
  task automatic directionLevels;
    wr(ECD_OFF_PH0_LO, 8'hA5);
    wr(ECD_OFF_PH0_HI, 8'h0F);
    wr(ECD_OFF_DIR_LO, 8'h00);
    wr(ECD_OFF_DIR_HI, 8'h3C);
    rdc(ECD_OFF_DIR_LO, 8'h00);
    rdc(ECD_OFF_DIR_HI, 8'h3C);
    check(pinsOe, 16'hC05A);
  endtask : directionLevels

  // every level, flip and enable mix with interrupts off
  task automatic blinkPin;
    logic [7:0] cfg;
    logic       lvl;
    wr(ECD_OFF_PH1_LO, 8'h0F);
    for (int i = 0; i < 16; i++) begin
      cfg = {2'b00, i[3], i[2], 2'b00, i[1], i[0]};
      lvl = (i[0] && i[1]) ? i[3] : i[2];
      wr(ECD_OFF_CONFIG, cfg);
      check(irqOe, !lvl);
      check(pinsOe[7:0], (i[0] && i[1]) ? 8'hF0 : 8'h5A);
    end
    wr(ECD_OFF_CONFIG, 8'h37);
    rdc(ECD_OFF_CONFIG, 8'h37);
  endtask : blinkPin

  task automatic intensity;
    wr(ECD_OFF_MASTER, 8'h09);
    wr(ECD_OFF_PORTINT, 8'h21);
    wr(ECD_OFF_CONFIG, 8'h00);
    check(inten[7:0], 8'h21);
    check(extraInt, 4'h9);
    wr(ECD_OFF_CONFIG, 8'h04);
    check(inten[7:0], 8'h99);
    check(inten[43:40], 4'h0);
    check(extraInt, 4'h9);
  endtask : intensity

  // status holds through a config read, clears on an input read
  task automatic changeIrq;
    wr(ECD_OFF_CONFIG, 8'hC8);
    host.readReg(ECD_OFF_IN_LO, rd);
    rdc(ECD_OFF_CONFIG, 8'h08);
    check(irqOe, 1'b0);
    @(posedge mclk);
    pins[10] <= 1'b0;
    repeat (5) @(posedge mclk);
    check(irqOe, 1'b1);
    rdc(ECD_OFF_CONFIG, 8'h88);
    check(irqOe, 1'b1);
    host.readReg(ECD_OFF_IN_HI, rd);
    check(irqOe, 1'b0);
    rdc(ECD_OFF_CONFIG, 8'h08);
  endtask : changeIrq

  // guard against a hung bus walk
  initial begin
    repeat (60000) @(posedge mclk);
    errorCnt++;
    wrapUp;
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    resetValues;
    directionLevels;
    blinkPin;
    intensity;
    changeIrq;
    check(host.nacks, 0);
    wrapUp;
  end
endmodule : ecd_expander_config_and_direction_tb
